// File: inc/wd_defines.svh
// Purpose: offsets, field positions, reset values and codes of the watchdog
// Assumes: byte addresses on a 32-bit avalon-mm slave port
// Notes: definitions only
`ifndef WD_DEFINES_SVH
`define WD_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WD_OFF_CTRL     8'h00
`define WD_OFF_TIMEOUT  8'h04
`define WD_OFF_PRESCALE 8'h08
`define WD_OFF_CLEAR    8'h0c
`define WD_OFF_LOCK     8'h10
`define WD_OFF_COUNT    8'h14
`define WD_OFF_STATUS   8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define WD_CTRL_COUNT_EN 0
`define WD_CTRL_IRQ_EN   1
`define WD_CTRL_RST_EN   2
`define WD_CTRL_SUSPEND  3
`define WD_CLEAR_IRQ     0
`define WD_CLEAR_RST     1
`define WD_STAT_IRQ      0
`define WD_STAT_RST      1
`define WD_STAT_LOCKED   2
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define WD_TIMEOUT_RST  32'hffff_ffff
`define WD_PRESCALE_RST 16'h0000
`define WD_LOCK_RST     32'h0000_0000
// unlock key, value arbitrary
`define WD_MAGIC        32'h5a5a_c3c3
`endif

// File: inc/wd_pkg.sv
// Purpose: types shared by the watchdog modules
// Assumes: nothing
// Notes: numbers live in wd_defines.svh
package wd_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLAVE_ERR = 2'b10,
        RESP_DECODE_ERR = 2'b11
    } resp_t;
    typedef struct packed {
        logic [31:0] count;
        logic [15:0] presc;
        logic irq_pend;
        logic rst_pend;
        logic expire;
    } core_st_t;
    typedef struct packed {
        logic [2:0] sync;
        logic tick;
        logic waitreq;
        resp_t resp;
        logic wr_ok;
        logic [31:0] rdata;
        logic [31:0] lock;
        logic count_en;
        logic irq_en;
        logic rst_en;
        logic suspend;
        logic [31:0] timeout;
        logic [15:0] prescale;
        logic load;
        logic clr_irq;
        logic clr_rst;
        logic irq;
        logic wd_reset;
    } top_st_t;
endpackage

// File: inc/wd_ctrl_if.sv
// Purpose: control and status between register side and timer core
// Assumes: one clock, core_clk
// Notes: load, tick, clears and expire are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface wd_ctrl_if;
    logic count_en;
    logic suspend;
    logic [31:0] timeout;
    logic [15:0] prescale;
    logic load;
    logic tick;
    logic clr_irq;
    logic clr_rst;
    logic [31:0] count;
    logic irq_pend;
    logic rst_pend;
    logic expire;
    modport regs (output count_en, suspend, timeout, prescale, load, tick, clr_irq, clr_rst,
                  input count, irq_pend, rst_pend, expire);
    modport core (input count_en, suspend, timeout, prescale, load, tick, clr_irq, clr_rst,
                  output count, irq_pend, rst_pend, expire);
endinterface
`default_nettype wire

// File: verilog/wd_timer_core.sv
// Purpose: prescaler and 32-bit down counter with expiry tracking
// Assumes: tick marks one timer clock edge, already synchronised
// Notes: clears lose to a same-cycle expiry
`timescale 1ns/1ps
`default_nettype none
`include "wd_defines.svh"
module wd_timer_core
    import wd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control and status
    wd_ctrl_if.core c
);
    core_st_t s;
    core_st_t next_s;
    logic run;

    // ----------------------------------------
    // counting
    // ----------------------------------------
    always_comb begin
        run = c.count_en && !c.suspend;
        next_s = s;
        next_s.expire = 1'b0;
        if (c.clr_irq) begin
            next_s.irq_pend = 1'b0;
        end
        if (c.clr_rst) begin
            next_s.rst_pend = 1'b0;
        end
        if (c.load) begin
            next_s.count = c.timeout;
            next_s.presc = 16'h0000;
        end else if (c.tick && run) begin
            if (s.presc == c.prescale) begin
                next_s.presc = 16'h0000;
                if (s.count == 32'h0000_0000) begin
                    next_s.count = c.timeout;
                    next_s.expire = 1'b1;
                    next_s.irq_pend = 1'b1;
                    // second expiry with the first still unserviced
                    if (s.irq_pend && !c.clr_irq) begin
                        next_s.rst_pend = 1'b1;
                    end
                end else begin
                    next_s.count = s.count - 32'h0000_0001;
                end
            end else begin
                next_s.presc = s.presc + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '{count: `WD_TIMEOUT_RST, presc: 16'h0000, default: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign c.count = s.count;
    assign c.irq_pend = s.irq_pend;
    assign c.rst_pend = s.rst_pend;
    assign c.expire = s.expire;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_DECREMENT: assert property (
        c.tick && run && !c.load && s.presc == c.prescale && s.count != 32'h0000_0000
        |=> s.count == $past(s.count) - 32'h0000_0001)
        else $error("counter did not decrement on prescaler expiry");
    AST_RELOAD: assert property (
        c.tick && run && !c.load && s.presc == c.prescale && s.count == 32'h0000_0000
        |=> s.count == $past(c.timeout) && s.expire && s.irq_pend)
        else $error("expiry did not reload and flag");
    AST_SECOND_EXPIRY: assert property (
        s.irq_pend && !c.clr_irq && c.tick && run && !c.load && s.presc == c.prescale
        && s.count == 32'h0000_0000 |=> s.rst_pend)
        else $error("unserviced second expiry did not raise reset");
    AST_SUSPEND_HOLDS: assert property (
        !run && !c.load |=> $stable(s.count) && $stable(s.presc))
        else $error("counter moved while suspended or disabled");
    AST_PRESCALE: assert property (
        c.tick && run && !c.load && s.presc != c.prescale
        |=> s.presc == $past(s.presc) + 16'h0001 && $stable(s.count))
        else $error("prescaler step wrong");
    COV_SECOND_EXPIRY: cover property (s.expire && s.rst_pend);
endmodule
`default_nettype wire

// File: verilog/wd_top.sv
// Purpose: watchdog with avalon-mm register slave and prescaled down counter
// Assumes: timer_clk is slow against core_clk and asynchronous to it
// Notes:
`timescale 1ns/1ps
`default_nettype none
`include "wd_defines.svh"
module wd_top
    import wd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output var logic [31:0] readdata,
    output var logic waitrequest,
    output var logic [1:0] response,
    // timer clock, sampled
    input wire logic timer_clk,
    // watchdog outputs
    output var logic irq,
    output var logic wd_reset
);
    top_st_t st;
    top_st_t next_st;
    logic req;
    logic grant;
    logic done;
    logic unlocked;
    logic cfg_target;
    resp_t next_resp;
    logic [31:0] rd_val;
    logic [31:0] presc_merged;

    wd_ctrl_if c();

    wd_timer_core u_core (
        .core_clk(core_clk),
        .rst(rst),
        .c(c)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == `WD_OFF_CTRL || a == `WD_OFF_TIMEOUT || a == `WD_OFF_PRESCALE
            || a == `WD_OFF_CLEAR || a == `WD_OFF_LOCK || a == `WD_OFF_COUNT
            || a == `WD_OFF_STATUS;
    endfunction

    // ----------------------------------------
    // register side and answer
    // ----------------------------------------
    always_comb begin
        req = read || write;
        // first wait cycle decides, the low-waitrequest cycle completes
        grant = req && st.waitreq && !st.wr_ok && st.resp == RESP_OKAY;
        done = req && !st.waitreq;
        unlocked = st.lock == `WD_MAGIC;
        cfg_target = address == `WD_OFF_CTRL || address == `WD_OFF_TIMEOUT
            || address == `WD_OFF_PRESCALE;
        // a function result cannot be part-selected, so widen through a net
        presc_merged = merge({16'h0000, st.prescale}, writedata, byteenable);
        rd_val = 32'h0000_0000;
        unique case (address)
            `WD_OFF_CTRL: begin
                rd_val[`WD_CTRL_COUNT_EN] = st.count_en;
                rd_val[`WD_CTRL_IRQ_EN] = st.irq_en;
                rd_val[`WD_CTRL_RST_EN] = st.rst_en;
                rd_val[`WD_CTRL_SUSPEND] = st.suspend;
            end
            `WD_OFF_TIMEOUT: rd_val = st.timeout;
            `WD_OFF_PRESCALE: rd_val = {16'h0000, st.prescale};
            `WD_OFF_LOCK: rd_val = st.lock;
            `WD_OFF_COUNT: rd_val = c.count;
            `WD_OFF_STATUS: begin
                rd_val[`WD_STAT_IRQ] = c.irq_pend;
                rd_val[`WD_STAT_RST] = c.rst_pend;
                rd_val[`WD_STAT_LOCKED] = !unlocked;
            end
            default: rd_val = 32'h0000_0000;
        endcase
        if (!is_mapped(address)) begin
            next_resp = RESP_DECODE_ERR;
        end else if (write && cfg_target && !unlocked) begin
            next_resp = RESP_SLAVE_ERR;
        end else begin
            next_resp = RESP_OKAY;
        end

        next_st = st;
        next_st.load = 1'b0;
        next_st.clr_irq = 1'b0;
        next_st.clr_rst = 1'b0;
        // sync[0] feeds only sync[1]; sync[2] is the delayed copy for edges
        next_st.sync = {st.sync[1:0], timer_clk};
        next_st.tick = st.sync[1] && !st.sync[2];
        next_st.irq = c.irq_pend && st.irq_en;
        next_st.wd_reset = c.rst_pend && st.rst_en;
        if (grant) begin
            next_st.waitreq = 1'b0;
            next_st.resp = next_resp;
            next_st.wr_ok = write && next_resp == RESP_OKAY;
            next_st.rdata = read ? rd_val : 32'h0000_0000;
        end else if (done) begin
            next_st.waitreq = 1'b1;
            next_st.resp = RESP_OKAY;
            next_st.wr_ok = 1'b0;
            if (st.wr_ok) begin
                unique case (address)
                    `WD_OFF_CTRL: begin
                        if (byteenable[0]) begin
                            next_st.count_en = writedata[`WD_CTRL_COUNT_EN];
                            next_st.irq_en = writedata[`WD_CTRL_IRQ_EN];
                            next_st.rst_en = writedata[`WD_CTRL_RST_EN];
                            next_st.suspend = writedata[`WD_CTRL_SUSPEND];
                        end
                    end
                    `WD_OFF_TIMEOUT: begin
                        next_st.timeout = merge(st.timeout, writedata, byteenable);
                        next_st.load = 1'b1;
                    end
                    `WD_OFF_PRESCALE: begin
                        next_st.prescale = presc_merged[15:0];
                    end
                    `WD_OFF_CLEAR: begin
                        // servicing stays open while locked
                        next_st.clr_irq = byteenable[0] && writedata[`WD_CLEAR_IRQ];
                        next_st.clr_rst = byteenable[0] && writedata[`WD_CLEAR_RST];
                    end
                    `WD_OFF_LOCK: next_st.lock = merge(st.lock, writedata, byteenable);
                    default: next_st.lock = st.lock;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{waitreq: 1'b1, resp: RESP_OKAY, timeout: `WD_TIMEOUT_RST,
                    prescale: `WD_PRESCALE_RST, lock: `WD_LOCK_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // wiring to core and pins
    // ----------------------------------------
    assign c.count_en = st.count_en;
    assign c.suspend = st.suspend;
    assign c.timeout = st.timeout;
    assign c.prescale = st.prescale;
    assign c.load = st.load;
    assign c.tick = st.tick;
    assign c.clr_irq = st.clr_irq;
    assign c.clr_rst = st.clr_rst;
    assign readdata = st.rdata;
    assign waitrequest = st.waitreq;
    assign response = st.resp;
    assign irq = st.irq;
    assign wd_reset = st.wd_reset;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_BUS_ANSWER: assert property (
        req && waitrequest && !st.wr_ok && st.resp == RESP_OKAY |=> !waitrequest)
        else $error("slave did not answer one cycle after request");
    AST_LOCKED_ERROR: assert property (
        write && !waitrequest && cfg_target && !unlocked |-> response == RESP_SLAVE_ERR)
        else $error("locked configuration write not answered with error");
    AST_LOCKED_NO_EFFECT: assert property (
        write && !waitrequest && cfg_target && !unlocked
        |=> $stable(st.timeout) && $stable(st.prescale) && $stable(st.count_en))
        else $error("locked configuration write took effect");
    AST_IRQ_FOLLOWS: assert property (
        c.expire && st.irq_en && !st.clr_irq |=> irq)
        else $error("interrupt not raised after expiry");
    AST_RESET_GATED: assert property (
        wd_reset |-> $past(st.rst_en) && $past(c.rst_pend))
        else $error("reset output without enable or pending flag");
    AST_IRQ_GATED: assert property (
        irq |-> $past(st.irq_en) && $past(c.irq_pend))
        else $error("interrupt output without enable or pending flag");
    AST_ANSWER_STANDS_ONE: assert property (
        !waitrequest |=> waitrequest)
        else $error("answer stood longer than one cycle");
    AST_TICK_SYNC: assert property (
        $rose(st.sync[1]) |=> st.tick ##1 !st.tick)
        else $error("timer clock edge not turned into one tick");
    COV_LOCK_ERR: cover property (response == RESP_SLAVE_ERR && !waitrequest);
    COV_IRQ: cover property ($rose(irq));
    COV_RESET: cover property ($rose(wd_reset));
endmodule
`default_nettype wire

// File: tb/wd_timer_src.sv
// Purpose: slow timer oscillator on the far side of the watchdog
// Assumes: 48 ns period while a burst is asked for
// Notes: stands low between bursts so tick counts stay exact
`timescale 1ns/1ps
`default_nettype none
module wd_timer_src (
    // timer clock
    output logic timer_clk
);
    initial timer_clk = 1'b0;
    // 2 ns start offset keeps all but every fifth edge off the core_clk edges
    task automatic pulses(input int n);
        #2;
        repeat (n) begin
            #24 timer_clk = 1'b1;
            #24 timer_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the watchdog top
// Assumes: timer edges counted by the design after about 3 core_clk
// Notes: register cases run from a table, timer cases by hand
`timescale 1ns/1ps
`default_nettype none
`include "wd_defines.svh"
module tb;
    import wd_pkg::*;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] q;
    } row_t;
    logic core_clk, rst, read, write, timer_clk, irq, wd_reset, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [1:0] response;
    int mismatches, check_count;
    row_t rows [0:20] = '{
        '{1'h0, `WD_OFF_TIMEOUT, 32'h0, RESP_OKAY, 32'hffff_ffff},
        '{1'h0, `WD_OFF_PRESCALE, 32'h0, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_STATUS, 32'h0, RESP_OKAY, 32'h4},
        '{1'h0, `WD_OFF_COUNT, 32'h0, RESP_OKAY, 32'hffff_ffff},
        '{1'h1, `WD_OFF_CTRL, 32'h7, RESP_SLAVE_ERR, 32'h0},
        '{1'h1, `WD_OFF_TIMEOUT, 32'h2, RESP_SLAVE_ERR, 32'h0},
        '{1'h1, `WD_OFF_PRESCALE, 32'h5, RESP_SLAVE_ERR, 32'h0},
        '{1'h0, `WD_OFF_TIMEOUT, 32'h0, RESP_OKAY, 32'hffff_ffff},
        '{1'h0, 8'h1c, 32'h0, RESP_DECODE_ERR, 32'h0},
        '{1'h1, 8'h20, 32'h1, RESP_DECODE_ERR, 32'h0},
        '{1'h1, `WD_OFF_LOCK, `WD_MAGIC, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_STATUS, 32'h0, RESP_OKAY, 32'h0},
        '{1'h1, `WD_OFF_PRESCALE, 32'h0001_ffff, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_PRESCALE, 32'h0, RESP_OKAY, 32'h0000_ffff},
        '{1'h1, `WD_OFF_PRESCALE, 32'h0, RESP_OKAY, 32'h0},
        '{1'h1, `WD_OFF_TIMEOUT, 32'h2, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_COUNT, 32'h0, RESP_OKAY, 32'h2},
        '{1'h1, `WD_OFF_COUNT, 32'h9, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_COUNT, 32'h0, RESP_OKAY, 32'h2},
        '{1'h1, `WD_OFF_CTRL, 32'h7, RESP_OKAY, 32'h0},
        '{1'h0, `WD_OFF_CLEAR, 32'h0, RESP_OKAY, 32'h0}
    };
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    wd_top i_dut (
        .core_clk(core_clk),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .response(response),
        .timer_clk(timer_clk),
        .irq(irq),
        .wd_reset(wd_reset)
    );
    wd_timer_src i_src (
        .timer_clk(timer_clk)
    );
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    // holds the request until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er, input logic [31:0] eq);
        int n;
        @(posedge core_clk);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        read <= 1'b0;
        write <= 1'b0;
        chk_bit("waitrequest", 1'b0, waitrequest);
        chk_val("response", {30'h0, er}, {30'h0, response});
        chk_val("readdata", eq, readdata);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] eq);
        acc(1'b0, a, 32'h0, RESP_OKAY, eq);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, RESP_OKAY, 32'h0);
    endtask
    // timer stands low afterwards, so nothing counts behind our back
    task automatic tick(input int n);
        i_src.pulses(n);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hf;
        mismatches = 0;
        check_count = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d, rows[i].r, rows[i].q);
        end
        tick(1);
        rd(`WD_OFF_COUNT, 32'h1);
        tick(1);
        rd(`WD_OFF_COUNT, 32'h0);
        chk_bit("irq", 1'b0, irq);
        tick(1);
        rd(`WD_OFF_COUNT, 32'h2);
        chk_bit("irq", 1'b1, irq);
        chk_bit("wd_reset", 1'b0, wd_reset);
        tick(3);
        chk_bit("wd_reset", 1'b1, wd_reset);
        rd(`WD_OFF_STATUS, 32'h3);
        wr(`WD_OFF_CLEAR, 32'h3);
        repeat (4) @(posedge core_clk);
        chk_bit("irq", 1'b0, irq);
        chk_bit("wd_reset", 1'b0, wd_reset);
        // masked interrupt still pends, unmasking shows it at once
        wr(`WD_OFF_CTRL, 32'h1);
        tick(3);
        chk_bit("irq", 1'b0, irq);
        rd(`WD_OFF_STATUS, 32'h1);
        wr(`WD_OFF_CTRL, 32'h3);
        repeat (4) @(posedge core_clk);
        chk_bit("irq", 1'b1, irq);
        wr(`WD_OFF_CLEAR, 32'h1);
        wr(`WD_OFF_CTRL, 32'h9);
        tick(2);
        rd(`WD_OFF_COUNT, 32'h2);
        wr(`WD_OFF_CTRL, 32'h1);
        tick(1);
        rd(`WD_OFF_COUNT, 32'h1);
        wr(`WD_OFF_PRESCALE, 32'h1);
        wr(`WD_OFF_TIMEOUT, 32'hffff_ffff);
        tick(1);
        rd(`WD_OFF_COUNT, 32'hffff_ffff);
        tick(1);
        rd(`WD_OFF_COUNT, 32'hffff_fffe);
        // only lane 1 lands; lane 0 keeps the prescale of 1
        byteenable <= 4'h2;
        wr(`WD_OFF_PRESCALE, 32'h1234_5678);
        byteenable <= 4'hf;
        rd(`WD_OFF_PRESCALE, 32'h0000_5601);
        wr(`WD_OFF_LOCK, 32'h0);
        acc(1'b1, `WD_OFF_TIMEOUT, 32'h3, RESP_SLAVE_ERR, 32'h0);
        rd(`WD_OFF_STATUS, 32'h4);
        // reset in mid-run brings every register home
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        chk_bit("waitrequest", 1'b1, waitrequest);
        chk_bit("irq", 1'b0, irq);
        rd(`WD_OFF_TIMEOUT, 32'hffff_ffff);
        end_of_test();
    end
endmodule
`default_nettype wire
